// ===== src/afmt_top.sv
// afmt_top: digital output stage of the sampling converter.
// assumes the core result, flags and mode pins come from other domains.
`timescale 1ns/100ps
// Contract
// R01 - bus A flag on over or under
// R02 - bus B flag on overflow
// R03 - differential flag on over or under
// R04 - forwarded clock copies delayed encode
// R05 - bus A changes on clock A fall
// R06 - demux bus B changes on A fall
// R07 - full rate drives only bus A
// R08 - demux clocks toggle at half rate
// R09 - receiver latches both on A rise
// R10 - scramble: xor lsb into upper bits
// R11 - receiver xors lsb back to decode
// R12 - lsb, flag, clock never scrambled
// R13 - scramble only while enable pin high
// R14 - dither from long pseudo-random generator
// R15 - subtract injected dither from result
// R16 - four output modes from mode pins
// R17 - offset binary or two's complement
// R18 - demux alternates samples B then A
// R19 - dither enable gates injection, subtraction
module afmt_top
(
  input  wire logic                        CLK,
  input  wire logic                        NRST,
  input  wire logic                        SAMPLE_CLOCK_IN,
  input  wire logic [afmt_pkg::DATA_W-1:0] CORE_CODE,
  input  wire logic                        CORE_OVER,
  input  wire logic                        CORE_UNDER,
  input  wire logic [1:0]                  OUT_MODE,
  input  wire logic [1:0]                  FMT_MODE,
  input  wire logic                        SCRAMBLE_ENABLE,
  input  wire logic [afmt_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [afmt_pkg::BUS_W-1:0]  WR_DATA,
  input  wire logic                        WR_EN,
  input  wire logic                        RD_EN,
  output logic [afmt_pkg::BUS_W-1:0]       RD_DATA,
  output logic [afmt_pkg::DATA_W-1:0]      DATA_A,
  output logic [afmt_pkg::DATA_W-1:0]      DATA_B,
  output logic                             OVERRANGE_FLAG_BUS_A,
  output logic                             OVERRANGE_FLAG_BUS_B,
  output logic                             OVERRANGE_FLAG,
  output logic                             FORWARDED_CLOCK_A,
  output logic                             FORWARDED_CLOCK_B,
  output logic                             FORWARDED_SAMPLE_CLOCK,
  output logic [afmt_pkg::DITH_W-1:0]      DITHER_CODE,
  output logic                             IRQ
);

  import afmt_pkg::*;

  logic              enc_s1_q, enc_s2_q, enc_s3_q;
  logic [DATA_W-1:0] raw_s1_q, raw_s2_q;
  logic [1:0]        ovun_s1_q, ovun_s2_q;
  logic [1:0]        mode_s1_q, mode_s2_q, fmt_s1_q, fmt_s2_q;
  logic              scr_s1_q, scr_s2_q;
  afmt_mode_t        mode_q;
  logic [1:0]        fmt_q;
  logic              scr_q;
  logic              enc_rise, enc_fall, is_cmos, twos;
  logic [DATA_W-1:0] plain_w, conv_d;
  logic [DATA_W-1:0] conv_q, held_q;
  logic              over_q, under_q, held_over_q;
  logic [DITH_W-1:0] dith_q;
  logic [LFSR_W-1:0] lfsr_state;
  logic              dither_en_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [IRQ_W-1:0]  irq_stat_q, irq_mask_q, irq_ev;
  logic              clk_a_q, clk_b_q, fwd_q;

  // xor the lsb into every upper bit; lsb itself passes untouched
  function automatic logic [DATA_W-1:0] scramble(
    input logic [DATA_W-1:0] w,
    input logic              en
  );
    scramble = en ? (w ^ {{(DATA_W-1){w[0]}}, 1'b0}) : w;
  endfunction

  // two flops on the system clock, core inputs and mode pins before any logic reads them; the register port is used directly
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      enc_s1_q  <= 1'b0;
      enc_s2_q  <= 1'b0;
      enc_s3_q  <= 1'b0;
      raw_s1_q  <= DATA_ZERO;
      raw_s2_q  <= DATA_ZERO;
      ovun_s1_q <= 2'h0;
      ovun_s2_q <= 2'h0;
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
      fmt_s1_q  <= 2'h0;
      fmt_s2_q  <= 2'h0;
      scr_s1_q  <= 1'b0;
      scr_s2_q  <= 1'b0;
    end else begin
      enc_s1_q  <= SAMPLE_CLOCK_IN;
      enc_s2_q  <= enc_s1_q;
      enc_s3_q  <= enc_s2_q;
      raw_s1_q  <= CORE_CODE;
      raw_s2_q  <= raw_s1_q;
      ovun_s1_q <= {CORE_UNDER, CORE_OVER};
      ovun_s2_q <= ovun_s1_q;
      mode_s1_q <= OUT_MODE;
      mode_s2_q <= mode_s1_q;
      fmt_s1_q  <= FMT_MODE;
      fmt_s2_q  <= fmt_s1_q;
      scr_s1_q  <= SCRAMBLE_ENABLE;
      scr_s2_q  <= scr_s1_q;
    end
  end

  // R16 mode select
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_q <= OM_FULL;
      fmt_q  <= 2'h0;
      scr_q  <= 1'b0;
    end else begin
      mode_q <= afmt_mode_t'(mode_s2_q);
      fmt_q  <= fmt_s2_q;
      scr_q  <= scr_s2_q;
    end
  end

  // edges of the sampled encode; conversion at rise, output at fall
  assign enc_rise = enc_s2_q & ~enc_s3_q;
  assign enc_fall = ~enc_s2_q & enc_s3_q;
  assign is_cmos  = (mode_q == OM_FULL) || (mode_q == OM_DEMUX);
  assign twos     = fmt_q[FMT_TWOS_BIT];

  // R15 dither removal, R17 format, R10 scramble
  always_comb begin
    plain_w = raw_s2_q - {{ZEXT_W{1'b0}}, dith_q};
    if (twos) begin
      plain_w = plain_w ^ SIGN_FLIP;
    end
    // R13 gated by pin
    conv_d = scramble(plain_w, scr_q);
  end

  // capture each conversion together with its flags
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      conv_q  <= DATA_ZERO;
      over_q  <= 1'b0;
      under_q <= 1'b0;
    end else if (enc_rise) begin
      conv_q  <= conv_d;
      over_q  <= ovun_s2_q[0];
      under_q <= ovun_s2_q[1];
    end
  end

  // R14 dither source, R19 zero when disabled
  // the value is advanced only after the sample that used it is taken,
  // so the subtraction always matches what the dither converter injected
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dith_q <= {DITH_W{1'b0}};
    end else if (enc_rise) begin
      dith_q <= dither_en_q ? lfsr_state[DITH_W-1:0] : {DITH_W{1'b0}};
    end
  end

  afmt_lfsr u_lfsr (
    .clk   (CLK),
    .nrst  (NRST),
    .step  (enc_rise),
    .state (lfsr_state)
  );

  // R04 forwarded clocks, R08 demux halves the rate
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      clk_a_q <= 1'b0;
      clk_b_q <= 1'b1;
      fwd_q   <= 1'b0;
    end else begin
      fwd_q <= is_cmos ? 1'b0 : enc_s2_q;
      unique case (mode_q)
        OM_FULL: begin
          clk_a_q <= enc_s2_q;
          clk_b_q <= ~enc_s2_q;
        end
        OM_DEMUX: begin
          if (enc_fall) begin
            clk_a_q <= ~clk_a_q;
            clk_b_q <= clk_a_q;
          end
        end
        OM_LVDS_LP, OM_LVDS: begin
          clk_a_q <= 1'b0;
          clk_b_q <= 1'b1;
        end
      endcase
    end
  end

  // R05 bus A update, R06 bus B update, R07 full rate leaves B idle
  // in demux the pair is launched while clock A falls, so the receiver
  // gets a whole encode period of setup before clock A rises again
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DATA_A               <= DATA_ZERO;
      DATA_B               <= DATA_ZERO;
      OVERRANGE_FLAG_BUS_A <= 1'b0;
      OVERRANGE_FLAG_BUS_B <= 1'b0;
      OVERRANGE_FLAG       <= 1'b0;
      held_q               <= DATA_ZERO;
      held_over_q          <= 1'b0;
    end else if (enc_fall) begin
      unique case (mode_q)
        OM_FULL: begin
          DATA_A               <= conv_q;
          DATA_B               <= DATA_ZERO;
          // R01 over or under on A
          OVERRANGE_FLAG_BUS_A <= over_q | under_q;
          OVERRANGE_FLAG_BUS_B <= 1'b0;
          OVERRANGE_FLAG       <= 1'b0;
        end
        OM_DEMUX: begin
          // R18 older sample to B, newer to A
          if (clk_a_q) begin
            DATA_A               <= conv_q;
            DATA_B               <= held_q;
            OVERRANGE_FLAG_BUS_A <= over_q | under_q;
            // R02 overflow only on B
            OVERRANGE_FLAG_BUS_B <= held_over_q;
          end else begin
            held_q      <= conv_q;
            held_over_q <= over_q;
          end
          OVERRANGE_FLAG <= 1'b0;
        end
        OM_LVDS_LP, OM_LVDS: begin
          DATA_A               <= conv_q;
          DATA_B               <= DATA_ZERO;
          OVERRANGE_FLAG_BUS_A <= 1'b0;
          OVERRANGE_FLAG_BUS_B <= 1'b0;
          // R03 single differential flag
          OVERRANGE_FLAG       <= over_q | under_q;
        end
      endcase
    end
  end

  // R12 clocks never pass through the scrambler
  assign FORWARDED_CLOCK_A      = clk_a_q;
  assign FORWARDED_CLOCK_B      = clk_b_q;
  assign FORWARDED_SAMPLE_CLOCK = fwd_q;
  assign DITHER_CODE            = dith_q;

  // conversion counter for software to see the stream is alive
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_q <= {CNT_W{1'b0}};
    end else if (enc_rise) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // events: flagged samples and a change of output mode
  always_comb begin
    irq_ev            = {IRQ_W{1'b0}};
    irq_ev[IRQ_OVER]  = enc_rise & ovun_s2_q[0];
    irq_ev[IRQ_UNDER] = enc_rise & ovun_s2_q[1];
    irq_ev[IRQ_MODE]  = (mode_s2_q != mode_q);
  end

  // control, mask and sticky status; a new event beats a clearing write
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dither_en_q <= 1'b0;
      irq_mask_q  <= {IRQ_W{1'b0}};
      irq_stat_q  <= {IRQ_W{1'b0}};
    end else begin
      if (WR_EN && ADDR == REG_CTRL) begin
        dither_en_q <= WR_DATA[CTRL_DITHER_BIT];
      end
      if (WR_EN && ADDR == REG_IRQ_MASK) begin
        irq_mask_q <= WR_DATA[IRQ_W-1:0];
      end
      if (WR_EN && ADDR == REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~WR_DATA[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  // read data stands only in the cycle after the strobe; unmapped reads 0
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RD_DATA <= BUS_ZERO;
    end else if (RD_EN) begin
      RD_DATA <= BUS_ZERO;
      unique case (ADDR)
        REG_CTRL:     RD_DATA[CTRL_DITHER_BIT] <= dither_en_q;
        REG_STATUS: begin
          RD_DATA[ST_MODE_LSB +: 2]     <= mode_q;
          RD_DATA[ST_FMT_LSB +: 2]      <= fmt_q;
          RD_DATA[ST_SCR_BIT]           <= scr_q;
          RD_DATA[ST_DITH_BIT]          <= dither_en_q;
          RD_DATA[ST_CNT_LSB +: CNT_W]  <= cnt_q;
        end
        REG_IRQ_STAT: RD_DATA[IRQ_W-1:0] <= irq_stat_q;
        REG_IRQ_MASK: RD_DATA[IRQ_W-1:0] <= irq_mask_q;
        default:      RD_DATA <= BUS_ZERO;
      endcase
    end else begin
      RD_DATA <= BUS_ZERO;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence full_fall_s;
    enc_fall && mode_q == OM_FULL;
  endsequence
  sequence demux_launch_s;
    enc_fall && mode_q == OM_DEMUX && clk_a_q;
  endsequence
  sequence mode_steady_s;
    mode_q == $past(mode_q);
  endsequence

  flag_a_full_a: assert property ( // R01
    full_fall_s |=> OVERRANGE_FLAG_BUS_A == $past(over_q | under_q))
    else $error("bus A flag wrong in full rate");
  flag_b_demux_a: assert property ( // R02
    demux_launch_s |=> OVERRANGE_FLAG_BUS_B == $past(held_over_q))
    else $error("bus B flag wrong in demux");
  flag_diff_a: assert property ( // R03
    enc_fall && !is_cmos |=> OVERRANGE_FLAG == $past(over_q | under_q))
    else $error("differential flag wrong");
  fwd_copy_a: assert property ( // R04
    !is_cmos ##1 mode_steady_s |-> FORWARDED_SAMPLE_CLOCK == $past(enc_s2_q))
    else $error("forwarded clock is not the encode copy");
  bus_a_edge_a: assert property ( // R05
    ($changed(DATA_A) && is_cmos && $past(is_cmos)) and mode_steady_s
      |-> $fell(FORWARDED_CLOCK_A) && $rose(FORWARDED_CLOCK_B))
    else $error("bus A changed off the clock A fall");
  bus_b_edge_a: assert property ( // R06
    ($changed(DATA_B) && mode_q == OM_DEMUX) and mode_steady_s
      |-> $fell(FORWARDED_CLOCK_A))
    else $error("bus B changed off the clock A fall");
  full_b_idle_a: assert property ( // R07
    full_fall_s |=> DATA_B == DATA_ZERO && !OVERRANGE_FLAG_BUS_B)
    else $error("bus B driven in full rate");
  demux_half_a: assert property ( // R08
    (mode_q == OM_DEMUX && $changed(FORWARDED_CLOCK_A)) and mode_steady_s
      |-> $past(enc_fall) && FORWARDED_CLOCK_B == !FORWARDED_CLOCK_A)
    else $error("demux clock not at half rate");
  scramble_lsb_a: assert property ( // R10
    enc_rise && scr_q |=> conv_q[0] == $past(plain_w[0])
      && (conv_q[DATA_W-1:1] ^ {(DATA_W-1){conv_q[0]}})
         == $past(plain_w[DATA_W-1:1]))
    else $error("scrambled word does not decode");
  plain_pass_a: assert property ( // R13
    enc_rise && !scr_q |=> conv_q == $past(plain_w))
    else $error("data scrambled with enable low");
  dither_src_a: assert property ( // R14
    enc_rise && dither_en_q |=> DITHER_CODE == $past(lfsr_state[DITH_W-1:0]))
    else $error("dither not from the generator");
  dither_off_a: assert property ( // R19
    enc_rise && !dither_en_q |=> DITHER_CODE == {DITH_W{1'b0}})
    else $error("dither injected while disabled");
  twos_fmt_a: assert property ( // R17
    enc_rise && twos && !scr_q |=> (conv_q ^ SIGN_FLIP)
      == $past(raw_s2_q - {{ZEXT_W{1'b0}}, dith_q}))
    else $error("two's complement word wrong");
  demux_alt_a: assert property ( // R18
    enc_fall && mode_q == OM_DEMUX && !clk_a_q |=> held_q == $past(conv_q)
      ##[1:2] 1'b1)
    else $error("demux did not park the sample for bus B");

endmodule

// ===== src/afmt_pkg.sv
// afmt_pkg: constants and types shared by the output formatter files.
// assumes a 16-bit converter core and a 125 MHz system clock.
package afmt_pkg;

  // sample word and dither widths
  localparam int DATA_W = 16;
  localparam int DITH_W = 8;
  localparam int ZEXT_W = DATA_W - DITH_W;

  // dither generator: x^31 + x^28 + 1, long period, never all zero
  localparam int              LFSR_W     = 31;
  localparam int              LFSR_TAP_A = 30;
  localparam int              LFSR_TAP_B = 27;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 31'h0000_0001;

  // output mode pins
  typedef enum logic [1:0] {
    OM_FULL    = 2'h0,
    OM_DEMUX   = 2'h1,
    OM_LVDS_LP = 2'h2,
    OM_LVDS    = 2'h3
  } afmt_mode_t;

  // format pin: upper bit selects two's complement
  localparam int                FMT_TWOS_BIT = 1;
  localparam logic [DATA_W-1:0] SIGN_FLIP    = 16'h8000;
  localparam logic [DATA_W-1:0] DATA_ZERO    = 16'h0000;

  // register port
  localparam int              ADDR_W       = 4;
  localparam int              BUS_W        = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hc;
  localparam logic [BUS_W-1:0]  BUS_ZERO     = 32'h0000_0000;

  // control register fields
  localparam int CTRL_DITHER_BIT = 0;

  // status register fields
  localparam int ST_MODE_LSB  = 0;
  localparam int ST_FMT_LSB   = 2;
  localparam int ST_SCR_BIT   = 4;
  localparam int ST_DITH_BIT  = 5;
  localparam int ST_CNT_LSB   = 16;
  localparam int CNT_W        = 16;

  // interrupt events
  localparam int IRQ_W     = 3;
  localparam int IRQ_OVER  = 0;
  localparam int IRQ_UNDER = 1;
  localparam int IRQ_MODE  = 2;

endpackage

// ===== src/afmt_lfsr.sv
// afmt_lfsr: pseudo-random source for the dither converter.
// assumes a one-cycle step pulse per conversion from the top module.
`timescale 1ns/100ps
module afmt_lfsr
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   step,
  output logic [afmt_pkg::LFSR_W-1:0] state
);

  import afmt_pkg::*;

  logic [LFSR_W-1:0] state_q;
  logic [LFSR_W-1:0] state_d;

  // shift left, feedback into bit zero; seed keeps it off the lock state
  always_comb begin
    state_d = {state_q[LFSR_W-2:0], state_q[LFSR_TAP_A] ^ state_q[LFSR_TAP_B]};
  end

  // advance once per conversion so each sample sees a fresh value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= LFSR_SEED;
    end else if (step) begin
      state_q <= state_d;
    end
  end

  assign state = state_q;

endmodule

// ===== dv/afmt_rx_model.sv
// afmt_rx_model: receiving logic that latches the converter output buses.
// assumes the system clock; it samples on the falling edge, away from launch.
`timescale 1ns/100ps
module afmt_rx_model
(
  input wire logic                        clk,
  input wire logic [1:0]                  mode,
  input wire logic                        descramble,
  input wire logic [afmt_pkg::DATA_W-1:0] data_a,
  input wire logic [afmt_pkg::DATA_W-1:0] data_b,
  input wire logic                        flag_a,
  input wire logic                        flag_b,
  input wire logic                        flag_d,
  input wire logic                        clk_a,
  input wire logic                        clk_s
);
  import afmt_pkg::*;

  logic [DATA_W:0]   rx_q[$];
  logic              cap_q = 1'b0;
  logic              a_q   = 1'b0;
  logic [DATA_W-1:0] da_q  = DATA_ZERO;
  logic [DATA_W-1:0] db_q  = DATA_ZERO;
  int                per_n = 0;
  int                per_q = 0;
  int                bad_n = 0;

  function automatic logic [DATA_W-1:0] undo(input logic [DATA_W-1:0] w);
    undo = descramble ? w ^ {{(DATA_W-1){w[0]}}, 1'b0} : w;
  endfunction

  // latch words and note data moving away from a clock A fall
  always @(negedge clk) begin
    per_n++;
    if ((mode[1] ? clk_s : clk_a) && !cap_q) begin
      per_q = per_n;
      per_n = 0;
      if (mode == OM_DEMUX)
        rx_q.push_back({flag_b, undo(data_b)});
      rx_q.push_back({mode[1] ? flag_d : flag_a, undo(data_a)});
    end
    // only meaningful in the CMOS modes, clock A is parked otherwise
    if (!mode[1] && (data_a !== da_q || data_b !== db_q) && !(a_q && !clk_a))
      bad_n++;
    cap_q = mode[1] ? clk_s : clk_a;
    a_q   = clk_a;
    da_q  = data_a;
    db_q  = data_b;
  end
endmodule

// ===== dv/tb_top.sv
// tb_top: self-checking bench for the converter output stage.
// assumes afmt_pkg and afmt_rx_model are compiled first.
`timescale 1ns/100ps
module tb_top;
  import afmt_pkg::*;
  localparam int          LIMIT = 30000;
  localparam logic [31:0] YES   = 32'h0000_0001;
  logic              CLK = 1'b0;
  logic              NRST = 1'b0;
  logic              SAMPLE_CLOCK_IN = 1'b0;
  logic [DATA_W-1:0] CORE_CODE = DATA_ZERO;
  logic              CORE_OVER = 1'b0;
  logic              CORE_UNDER = 1'b0;
  logic [1:0]        OUT_MODE = 2'h0;
  logic [1:0]        FMT_MODE = 2'h0;
  logic              SCRAMBLE_ENABLE = 1'b0;
  logic [ADDR_W-1:0] ADDR = 4'h0;
  logic [BUS_W-1:0]  WR_DATA = BUS_ZERO;
  logic              WR_EN = 1'b0;
  logic              RD_EN = 1'b0;
  logic [BUS_W-1:0]  RD_DATA;
  logic [DATA_W-1:0] DATA_A;
  logic [DATA_W-1:0] DATA_B;
  logic              OVERRANGE_FLAG_BUS_A;
  logic              OVERRANGE_FLAG_BUS_B;
  logic              OVERRANGE_FLAG;
  logic              FORWARDED_CLOCK_A;
  logic              FORWARDED_CLOCK_B;
  logic              FORWARDED_SAMPLE_CLOCK;
  logic [DITH_W-1:0] DITHER_CODE;
  logic              IRQ;
  logic [DATA_W+1:0] src_q[$];
  logic [DATA_W:0]   exp_q[$];
  logic [1:0]        enc_q = 2'h0;
  logic [DITH_W-1:0] dith_q = 8'h00;
  int                dith_chg = 0;
  int                dith_bad = 0;
  int                err_total = 0;
  int                n_compared = 0;
  int                cyc = 0;

  afmt_top dut (
    .CLK(CLK), .NRST(NRST), .SAMPLE_CLOCK_IN(SAMPLE_CLOCK_IN),
    .CORE_CODE(CORE_CODE), .CORE_OVER(CORE_OVER), .CORE_UNDER(CORE_UNDER),
    .OUT_MODE(OUT_MODE), .FMT_MODE(FMT_MODE),
    .SCRAMBLE_ENABLE(SCRAMBLE_ENABLE), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .DATA_A(DATA_A),
    .DATA_B(DATA_B), .OVERRANGE_FLAG_BUS_A(OVERRANGE_FLAG_BUS_A),
    .OVERRANGE_FLAG_BUS_B(OVERRANGE_FLAG_BUS_B),
    .OVERRANGE_FLAG(OVERRANGE_FLAG), .FORWARDED_CLOCK_A(FORWARDED_CLOCK_A),
    .FORWARDED_CLOCK_B(FORWARDED_CLOCK_B),
    .FORWARDED_SAMPLE_CLOCK(FORWARDED_SAMPLE_CLOCK),
    .DITHER_CODE(DITHER_CODE), .IRQ(IRQ));

  afmt_rx_model rx (
    .clk(CLK), .mode(OUT_MODE), .descramble(SCRAMBLE_ENABLE),
    .data_a(DATA_A), .data_b(DATA_B), .flag_a(OVERRANGE_FLAG_BUS_A),
    .flag_b(OVERRANGE_FLAG_BUS_B), .flag_d(OVERRANGE_FLAG),
    .clk_a(FORWARDED_CLOCK_A), .clk_s(FORWARDED_SAMPLE_CLOCK));

  // system clock, and an encode clock of unrelated phase
  always #4 CLK = ~CLK;
  initial begin
    #3.3;
    forever #80 SAMPLE_CLOCK_IN = ~SAMPLE_CLOCK_IN;
  end

  // core model: result plus injected dither, launched after encode falls
  always @(posedge CLK) begin
    enc_q <= {enc_q[0], SAMPLE_CLOCK_IN};
    if (enc_q == 2'h2 && src_q.size() > 0) begin
      CORE_OVER  <= src_q[0][DATA_W+1];
      CORE_UNDER <= src_q[0][DATA_W];
      CORE_CODE  <= src_q[0][DATA_W-1:0] + DATA_W'(DITHER_CODE);
      dith_chg   <= dith_chg + int'(DITHER_CODE != dith_q);
      // one conversion apart, a fresh value is the last one shifted once
      dith_bad   <= dith_bad + int'(DITHER_CODE != '0 && dith_q != '0 &&
                    DITHER_CODE[DITH_W-1:1] != dith_q[DITH_W-2:0]);
      dith_q     <= DITHER_CODE;
      void'(src_q.pop_front());
    end
  end

  // a hang is cut short here
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want,
                     input string msg);
    n_compared++;
    if (got !== want) begin
      err_total++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
    @(posedge CLK);
    ADDR    <= a;
    WR_DATA <= d;
    WR_EN   <= 1'b1;
    @(posedge CLK);
    WR_EN   <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] d);
    @(posedge CLK);
    ADDR  <= a;
    RD_EN <= 1'b1;
    @(posedge CLK);
    RD_EN <= 1'b0;
    #1 d = RD_DATA;
  endtask

  // twelve words with edge codes, then search the receiver log for them
  task automatic stream(input logic [1:0] m, input logic [1:0] f,
                        input logic s, input logic [1:0] fl);
    logic [DATA_W-1:0] raw;
    logic              ov;
    logic              un;
    int                at;
    @(posedge CLK);
    OUT_MODE        <= m;
    FMT_MODE        <= f;
    SCRAMBLE_ENABLE <= s;
    repeat (120) @(posedge CLK);
    rx.rx_q.delete();
    rx.bad_n = 0;
    exp_q.delete();
    for (int k = 0; k < 12; k++) begin
      raw = 16'h3c5b * k[15:0] ^ 16'hfffe;
      ov  = fl[0] && (k % 3 == 1);
      un  = fl[1] && (k % 3 == 2);
      src_q.push_back({ov, un, raw});
      exp_q.push_back({ov | un, raw ^ (f[1] ? SIGN_FLIP : DATA_ZERO)});
    end
    for (int i = 0; i < 400 && src_q.size() > 0; i++)
      @(posedge CLK);
    repeat (100) @(posedge CLK);
    // step off the edge so callers see settled outputs
    #1;
    at = -1;
    for (int i = rx.rx_q.size() - 1; i >= 0; i--)
      if (rx.rx_q[i] === exp_q[0])
        at = i;
    chk(32'(at >= 0), YES, "first word never seen");
    for (int j = 1; j < exp_q.size() && at >= 0; j++)
      chk(32'(rx.rx_q[at + j]), 32'(exp_q[j]), "received word wrong");
  endtask

  task automatic t_full();
    stream(OM_FULL, 2'h0, 1'b0, 2'h3);
    chk(32'(rx.bad_n), 0, "bus A moved off clock A fall");
    chk(DATA_B, 0, "bus B driven in full rate");
    chk(OVERRANGE_FLAG, 0, "diff flag in CMOS");
    chk(32'(rx.per_q > 18 && rx.per_q < 22), YES, "clock A period");
  endtask

  task automatic t_demux();
    stream(OM_DEMUX, 2'h2, 1'b0, 2'h1);
    chk(32'(rx.bad_n), 0, "buses moved off clock A fall");
    chk(32'(rx.per_q > 38 && rx.per_q < 42), YES, "half rate clock");
    chk(FORWARDED_CLOCK_B, !FORWARDED_CLOCK_A, "clock B not inverse");
  endtask

  task automatic t_diff();
    afmt_mode_t md[2] = '{OM_LVDS_LP, OM_LVDS};
    foreach (md[i]) begin
      stream(md[i], 2'h3, 1'b0, 2'h3);
      chk({FORWARDED_CLOCK_A, FORWARDED_CLOCK_B}, 2'h1, "parked");
      chk(32'(rx.per_q > 18 && rx.per_q < 22), YES, "sample clock");
    end
  endtask

  task automatic t_scramble();
    stream(OM_FULL, 2'h0, 1'b1, 2'h3);
  endtask

  task automatic t_dither();
    int               c0;
    logic [BUS_W-1:0] d;
    wr(REG_CTRL, YES);
    rd(REG_CTRL, d);
    chk(d, YES, "dither enable not read back");
    c0 = dith_chg;
    stream(OM_FULL, 2'h0, 1'b0, 2'h0);
    chk(32'(dith_chg - c0 > 0), YES, "dither value stuck");
    chk(32'(dith_bad), 0, "dither not from the shifter");
    wr(REG_CTRL, BUS_ZERO);
    repeat (60) @(posedge CLK);
    chk(DITHER_CODE, 0, "dither not zero when off");
  endtask

  task automatic t_regs();
    logic [BUS_W-1:0] d;
    @(posedge CLK);
    OUT_MODE        <= OM_DEMUX;
    FMT_MODE        <= 2'h2;
    SCRAMBLE_ENABLE <= 1'b1;
    repeat (20) @(posedge CLK);
    rd(REG_STATUS, d);
    chk(d & 32'h0000_003f, 32'h0000_0019, "status pins");
    wr(REG_IRQ_MASK, BUS_ZERO);
    wr(REG_IRQ_STAT, 32'h0000_0007);
    rd(REG_IRQ_STAT, d);
    chk(d, BUS_ZERO, "events not cleared");
    src_q.push_back({2'h2, 16'h7ff0});
    src_q.push_back({2'h1, 16'h7ff2});
    src_q.push_back({2'h0, 16'h7ff1});
    repeat (120) @(posedge CLK);
    rd(REG_IRQ_STAT, d);
    chk(d, 32'h0000_0003, "sample events missing");
    chk(IRQ, 0, "masked event raised irq");
    wr(REG_IRQ_MASK, YES);
    #1 chk(IRQ, YES, "irq not raised");
    rd(REG_IRQ_MASK, d);
    chk(d, YES, "mask not read back");
    wr(REG_IRQ_STAT, YES);
    #1 chk(IRQ, 0, "irq not cleared");
    rd(4'h2, d);
    chk(d, BUS_ZERO, "unmapped read not zero");
    rd(REG_STATUS, d);
    #8 chk(RD_DATA, BUS_ZERO, "read data held too long");
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    t_full();
    t_demux();
    t_diff();
    t_scramble();
    t_dither();
    t_regs();
    summarize();
  end
endmodule
